// File: common/pcm_pkg.sv
// constants, register map and ratio decoding for the pll clock multiplier control
// assumes a single 40 MHz system clock and a plain strobe register port
// How it works
// - the multiplied clock runs at the reference rate times a pin-selected ratio of 4 to 40.
// - five select pins, msb first, map to ratios 4, 6, 8-10, 12-19, 20 and 22-40 by two.
// - with enable low the block is disabled and both clock outputs float.
// - with enable high and supply good the multiplier runs and its output is driven; the link output also needs its own enable high.
// - a power-on reset (supply below threshold) disables the block just like enable low.
// - the link reference output floats when its own enable is low, independent of the other.
// - after any reset the lock output stays low until lock is reached.
// - lock is signalled by the lock output going from low to high.
// - the link reference output carries the data-block sync clock at the reference rate.
// - lock is raised within 1 ms of the reference being applied, typically 0.2 ms.
package pcm_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 40;
   localparam int LOCK_TYP_US      = 200;
   localparam int LOCK_MAX_US      = 1000;
   localparam int LOCK_TYP_CYC     = LOCK_TYP_US * CLK_MHZ;
   localparam int LOCK_MAX_CYC     = LOCK_MAX_US * CLK_MHZ;
   // slowest legal reference is 200 ns; twice that means the reference is gone
   localparam int REF_LOSS_NS      = 400;
   localparam int REF_LOSS_CYC     = (REF_LOSS_NS * CLK_MHZ) / 1000;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
   localparam logic [7:0] ADDR_PERIOD   = 8'h10;

   localparam int CTRL_RELOCK_BIT  = 0;
   localparam int ST_LOCK_BIT      = 0;
   localparam int ST_REF_BIT       = 1;
   localparam int ST_BAND_BIT      = 2;
   localparam int ST_EN_BIT        = 3;
   localparam int ST_SUPPLY_BIT    = 4;
   localparam int ST_LREN_BIT      = 5;
   localparam int ST_INVALID_BIT   = 6;
   localparam int ST_CODE_LSB      = 8;
   localparam int ST_RATIO_LSB     = 16;
   localparam int NUM_EVT          = 4;
   localparam int EVT_LOCK_GAIN    = 0;
   localparam int EVT_LOCK_LOST    = 1;
   localparam int EVT_RESERVED     = 2;
   localparam int EVT_CODE_CHG     = 3;
   localparam logic [NUM_EVT-1:0] INT_MASK_RST = 4'h0;

   typedef enum {PCM_OFF, PCM_ACQUIRE, PCM_LOCKED, PCM_INVALID} pcm_state_e;

   // ----------------------------------------------------------------
   // select code to ratio; zero marks a reserved code
   // ----------------------------------------------------------------
   function automatic logic [5:0] ratio_of(input logic [4:0] code);
      logic [5:0] r;
      r = 6'h00;
      if (code == 5'h00) begin
         r = 6'h04;
      end else if (code == 5'h02) begin
         r = 6'h06;
      end else if (code >= 5'h04 && code <= 5'h06) begin
         r = 6'({1'b0, code} + 6'h04);
      end else if (code >= 5'h08 && code <= 5'h10) begin
         r = 6'({1'b0, code} + 6'h04);
      end else if (code >= 5'h11 && code <= 5'h1a) begin
         r = 6'({code, 1'b0} - 6'h0c);
      end
      return r;
   endfunction

endpackage

// File: rtl/pcm_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes the inputs are asynchronous static or slow pins
`timescale 1ns/100ps
`default_nettype none
module pcm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   initial begin
      if (WIDTH < 1) $error("pcm_sync: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] ff1_r, ff2_r, ff3_r, out_r;
   logic [WIDTH-1:0] out_nxt;

   // ----------------------------------------------------------------
   // filter
   // ----------------------------------------------------------------
   // a bit moves only once the second and third stages agree
   always_comb begin
      out_nxt = (ff2_r & ~(ff2_r ^ ff3_r)) | (out_r & (ff2_r ^ ff3_r));
   end

   // ff1 feeds ff2 only, to keep metastability out of the compare
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff1_r <= '0;
         ff2_r <= '0;
         ff3_r <= '0;
         out_r <= '0;
      end else begin
         ff1_r <= i_async;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
         out_r <= out_nxt;
      end
   end

   assign o_sync = out_r;

endmodule // pcm_sync
`default_nettype wire

// File: rtl/pcm_top.sv
// pll clock multiplier control: pin decode, lock tracking, output gating, registers
// assumes all pins are asynchronous to i_clk_sys and the bus master is on i_clk_sys
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module pcm_top #(
   parameter int LOCK_CYCLES = pcm_pkg::LOCK_TYP_CYC
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   // pins
   input  wire logic        i_ref_clk_in,
   input  wire logic [4:0]  i_ratio_select,
   input  wire logic        i_band_select,
   input  wire logic        i_enable,
   input  wire logic        i_supply_ok,
   input  wire logic        i_link_ref_out_enable,
   output logic             o_mult_clk_out_p,
   output logic             o_mult_clk_out_n,
   output logic             o_mult_clk_out_oe_n,
   output logic             o_link_ref_clk_out_p,
   output logic             o_link_ref_clk_out_n,
   output logic             o_link_ref_clk_out_oe_n,
   output logic             o_lock_valid_out,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   output logic             o_irq
);

   initial begin
      if (LOCK_CYCLES < 1 || LOCK_CYCLES > pcm_pkg::LOCK_MAX_CYC)
         $error("pcm_top: LOCK_CYCLES outside 1 .. 1 ms");
   end

   localparam logic [15:0] LOCK_LAST = 16'(LOCK_CYCLES - 1);
   localparam logic [7:0]  LOSS_CYC  = 8'(pcm_pkg::REF_LOSS_CYC);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [9:0] pins_s;
   logic       ref_s, band_s, en_s, supply_s, lren_s;
   logic [4:0] code_s;

   pcm_sync #(
      .WIDTH (10)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   ({i_ref_clk_in, i_ratio_select, i_band_select, i_enable,
                   i_supply_ok, i_link_ref_out_enable}),
      .o_sync    (pins_s)
   );

   assign ref_s    = pins_s[9];
   assign code_s   = pins_s[8:4];
   assign band_s   = pins_s[3];
   assign en_s     = pins_s[2];
   assign supply_s = pins_s[1];
   assign lren_s   = pins_s[0];

   // ----------------------------------------------------------------
   // reference edge, period and presence
   // ----------------------------------------------------------------
   logic       ref_d_r, ref_d_nxt;
   logic [7:0] gap_r, gap_nxt;
   logic [7:0] period_r, period_nxt;
   logic       seen_r, seen_nxt;
   logic       ref_rise, ref_ok;

   assign ref_rise = ref_s & ~ref_d_r;
   assign ref_ok   = seen_r && (gap_r < LOSS_CYC);

   // gap saturates so a stopped reference stays flagged absent
   always_comb begin
      ref_d_nxt  = ref_s;
      gap_nxt    = (gap_r == 8'hff) ? gap_r : 8'(gap_r + 8'h01);
      period_nxt = period_r;
      seen_nxt   = seen_r;
      if (ref_rise) begin
         gap_nxt    = 8'h00;
         period_nxt = (gap_r == 8'hff) ? gap_r : 8'(gap_r + 8'h01);
         seen_nxt   = 1'b1;
      end else if (gap_r >= LOSS_CYC) begin
         seen_nxt   = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_d_r  <= 1'b0;
         gap_r    <= 8'hff;
         period_r <= 8'h00;
         seen_r   <= 1'b0;
      end else begin
         ref_d_r  <= ref_d_nxt;
         gap_r    <= gap_nxt;
         period_r <= period_nxt;
         seen_r   <= seen_nxt;
      end
   end

   // ----------------------------------------------------------------
   // lock state machine
   // ----------------------------------------------------------------
   pcm_pkg::pcm_state_e state_r, state_nxt;
   logic [15:0] lcnt_r, lcnt_nxt;
   logic [4:0]  code_d_r;
   logic [5:0]  ratio;
   logic        active, code_chg, relock;

   assign ratio    = pcm_pkg::ratio_of(code_s);
   assign active   = en_s & supply_s;
   assign code_chg = (code_s != code_d_r);
   assign relock   = i_wr && (i_addr == pcm_pkg::ADDR_CTRL)
                     && i_wdata[pcm_pkg::CTRL_RELOCK_BIT];

   always_comb begin
      state_nxt = state_r;
      lcnt_nxt  = lcnt_r;
      if (!active) begin
         state_nxt = pcm_pkg::PCM_OFF;
         lcnt_nxt  = 16'h0000;
      end else if (code_chg || relock || state_r == pcm_pkg::PCM_OFF) begin
         // restart on any new code; reserved codes park in invalid
         state_nxt = (ratio == 6'h00) ? pcm_pkg::PCM_INVALID
                                      : pcm_pkg::PCM_ACQUIRE;
         lcnt_nxt  = 16'h0000;
      end else begin
         case (state_r)
            pcm_pkg::PCM_ACQUIRE: begin
               if (!ref_ok) begin
                  lcnt_nxt = 16'h0000;
               end else if (lcnt_r == LOCK_LAST) begin
                  state_nxt = pcm_pkg::PCM_LOCKED;
               end else begin
                  lcnt_nxt = 16'(lcnt_r + 16'h0001);
               end
            end
            pcm_pkg::PCM_LOCKED: begin
               if (!ref_ok) begin
                  state_nxt = pcm_pkg::PCM_ACQUIRE;
               end
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r  <= pcm_pkg::PCM_OFF;
         lcnt_r   <= 16'h0000;
         code_d_r <= 5'h00;
      end else begin
         state_r  <= state_nxt;
         lcnt_r   <= lcnt_nxt;
         code_d_r <= code_s;
      end
   end

   // ----------------------------------------------------------------
   // multiplied clock generator
   // ----------------------------------------------------------------
   // toggles 2*ratio times per measured period; above half the system
   // rate the output saturates, so this is a behavioural stand-in only
   logic [8:0] acc_r, acc_nxt;
   logic [8:0] acc_sum;
   logic       mclk_r, mclk_nxt;
   logic       lref_r, lref_nxt;
   logic       drv_r, drv_nxt;
   logic       lren_r, lren_nxt;
   logic       lock_r, lock_nxt;

   assign acc_sum = 9'(acc_r + {2'b00, ratio, 1'b0});

   always_comb begin
      acc_nxt  = acc_r;
      mclk_nxt = 1'b0;
      if (state_r == pcm_pkg::PCM_ACQUIRE || state_r == pcm_pkg::PCM_LOCKED) begin
         mclk_nxt = mclk_r;
         acc_nxt  = acc_sum;
         if (acc_sum >= {1'b0, period_r}) begin
            mclk_nxt = ~mclk_r;
            acc_nxt  = 9'(acc_sum - {1'b0, period_r});
            if (acc_nxt >= {1'b0, period_r}) acc_nxt = 9'h000;
         end
      end else begin
         acc_nxt = 9'h000;
      end
      lref_nxt = active & ref_s;
      drv_nxt  = active;
      lren_nxt = active & lren_s;
      lock_nxt = (state_nxt == pcm_pkg::PCM_LOCKED);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_r  <= 9'h000;
         mclk_r <= 1'b0;
         lref_r <= 1'b0;
         drv_r  <= 1'b0;
         lren_r <= 1'b0;
         lock_r <= 1'b0;
      end else begin
         acc_r  <= acc_nxt;
         mclk_r <= mclk_nxt;
         lref_r <= lref_nxt;
         drv_r  <= drv_nxt;
         lren_r <= lren_nxt;
         lock_r <= lock_nxt;
      end
   end

   // enables are active low: low while the pair is driven
   assign o_mult_clk_out_p        = mclk_r;
   assign o_mult_clk_out_n        = ~mclk_r;
   assign o_mult_clk_out_oe_n     = ~drv_r;
   assign o_link_ref_clk_out_p    = lref_r;
   assign o_link_ref_clk_out_n    = ~lref_r;
   assign o_link_ref_clk_out_oe_n = ~lren_r;
   assign o_lock_valid_out        = lock_r;

   // ----------------------------------------------------------------
   // events, interrupt status and mask
   // ----------------------------------------------------------------
   logic [pcm_pkg::NUM_EVT-1:0] evt, ist_r, ist_nxt, msk_r, msk_nxt;
   logic                        irq_r, irq_nxt;

   always_comb begin
      evt = '0;
      evt[pcm_pkg::EVT_LOCK_GAIN] = lock_nxt & ~lock_r;
      evt[pcm_pkg::EVT_LOCK_LOST] = lock_r & ~lock_nxt;
      evt[pcm_pkg::EVT_RESERVED]  = (state_nxt == pcm_pkg::PCM_INVALID)
                                    && (state_r != pcm_pkg::PCM_INVALID);
      evt[pcm_pkg::EVT_CODE_CHG]  = code_chg & active;
      ist_nxt = ist_r;
      msk_nxt = msk_r;
      if (i_wr && i_addr == pcm_pkg::ADDR_INT_STAT) begin
         ist_nxt = ist_r & ~i_wdata[pcm_pkg::NUM_EVT-1:0];
      end
      if (i_wr && i_addr == pcm_pkg::ADDR_INT_MASK) begin
         msk_nxt = i_wdata[pcm_pkg::NUM_EVT-1:0];
      end
      // a new event beats a simultaneous clear
      ist_nxt = ist_nxt | evt;
      irq_nxt = |(ist_nxt & msk_nxt);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ist_r <= '0;
         msk_r <= pcm_pkg::INT_MASK_RST;
         irq_r <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         msk_r <= msk_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign o_irq = irq_r;

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   logic [31:0] status, rdata_r, rdata_nxt;

   always_comb begin
      status = 32'h0000_0000;
      status[pcm_pkg::ST_LOCK_BIT]    = lock_r;
      status[pcm_pkg::ST_REF_BIT]     = ref_ok;
      status[pcm_pkg::ST_BAND_BIT]    = band_s;
      status[pcm_pkg::ST_EN_BIT]      = en_s;
      status[pcm_pkg::ST_SUPPLY_BIT]  = supply_s;
      status[pcm_pkg::ST_LREN_BIT]    = lren_s;
      status[pcm_pkg::ST_INVALID_BIT] = (state_r == pcm_pkg::PCM_INVALID);
      status[pcm_pkg::ST_CODE_LSB +: 5]  = code_s;
      status[pcm_pkg::ST_RATIO_LSB +: 6] = ratio;
   end

   // data stand for one cycle only; unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (i_rd) begin
         if (i_addr == pcm_pkg::ADDR_STATUS) begin
            rdata_nxt = status;
         end else if (i_addr == pcm_pkg::ADDR_INT_STAT) begin
            rdata_nxt = {28'h0000000, ist_r};
         end else if (i_addr == pcm_pkg::ADDR_INT_MASK) begin
            rdata_nxt = {28'h0000000, msk_r};
         end else if (i_addr == pcm_pkg::ADDR_PERIOD) begin
            rdata_nxt = {24'h000000, period_r};
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;

endmodule // pcm_top
`default_nettype wire

// File: tb/pcm_chk.sv
// checker for the clock multiplier control: gating, lock and pair rules
// assumes a bind onto pcm_top; sees only the top ports it names
`timescale 1ns/100ps
`default_nettype none
module pcm_chk #(
   parameter int LOCK_CYCLES = pcm_pkg::LOCK_TYP_CYC
) (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_n,
   input wire logic [4:0] i_ratio_select,
   input wire logic       i_enable,
   input wire logic       i_supply_ok,
   input wire logic       i_link_ref_out_enable,
   input wire logic       o_mult_clk_out_p,
   input wire logic       o_mult_clk_out_n,
   input wire logic       o_mult_clk_out_oe_n,
   input wire logic       o_link_ref_clk_out_oe_n,
   input wire logic       o_lock_valid_out
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic rsv;
   int   low_cnt;
   // codes with no ratio behind them
   assign rsv = (i_ratio_select inside {5'h01, 5'h03, 5'h07}) || (i_ratio_select > 5'h1a);
   // time spent unlocked, saturating so long idles cannot wrap
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= o_lock_valid_out ? 0 : ((low_cnt < 100000) ? low_cnt + 1 : low_cnt);
      end
   end
   // pins need seven samples: three sync flops, filter and output flop
   sequence s_off;
      (!i_enable || !i_supply_ok) [*7];
   endsequence
   sequence s_code_move;
      $changed(i_ratio_select) ##1 $stable(i_ratio_select) [*5];
   endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_off_mult_hiz: assert property (s_off |-> o_mult_clk_out_oe_n)
      else $error("mult pair driven while disabled");
   a_off_link_hiz: assert property (s_off |-> o_link_ref_clk_out_oe_n)
      else $error("link pair driven while disabled");
   a_off_no_lock: assert property (s_off |-> !o_lock_valid_out)
      else $error("lock high while disabled");
   a_run_driven: assert property ((i_enable && i_supply_ok) [*7] |-> !o_mult_clk_out_oe_n)
      else $error("mult pair floating while enabled");
   a_link_en_off: assert property (!i_link_ref_out_enable [*7] |-> o_link_ref_clk_out_oe_n)
      else $error("link pair driven with its enable low");
   a_link_driven: assert property ((i_enable && i_supply_ok && i_link_ref_out_enable) [*7]
      |-> !o_link_ref_clk_out_oe_n)
      else $error("link pair floating with all enables high");
   a_rsv_no_lock: assert property (rsv [*7] |-> !o_lock_valid_out && !o_mult_clk_out_p)
      else $error("reserved code gave lock or clock");
   a_lock_wait: assert property ($rose(o_lock_valid_out) |-> low_cnt >= LOCK_CYCLES)
      else $error("lock rose before the lock time");
   a_code_drop: assert property (s_code_move |=> !o_lock_valid_out)
      else $error("lock held across a code change");
   a_pair_comp: assert property (!o_mult_clk_out_oe_n |-> o_mult_clk_out_n != o_mult_clk_out_p)
      else $error("mult pair not complementary");
endmodule // pcm_chk
`default_nettype wire

// File: tb/pcm_ser.sv
// companion serializer model: makes the reference, eats lock and mult clock
// assumes the mult clock toggles no faster than the system clock
`timescale 1ns/100ps
`default_nettype none
module pcm_ser #(
   parameter int HALF_NS = 175
) (
   input  wire logic i_clk_sys,
   input  wire logic i_run,
   input  wire logic i_lock_valid_in,
   input  wire logic i_mult_clk,
   input  wire logic i_mult_oe_n,
   output logic      o_ref_clk,
   output int        o_shift_cnt
);
   logic prev;
   int   cnt = 0;
   // parallel data clock as reference; parks low when stopped
   // kept slow so the multiplied clock stays under its ceiling at the measured ratios 4 and 6
   initial begin
      o_ref_clk = 1'b0;
      #3;
      forever begin
         #(HALF_NS);
         o_ref_clk = i_run ? ~o_ref_clk : 1'b0;
      end
   end
   // shift only on a driven mult clock and only once lock is high
   assign o_shift_cnt = cnt;
   always @(posedge i_clk_sys) begin
      prev <= i_mult_clk;
      if (i_lock_valid_in === 1'b1 && i_mult_oe_n === 1'b0 && i_mult_clk && !prev) begin
         cnt <= cnt + 1;
      end
   end
endmodule // pcm_ser
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for pcm_top with the companion model on its far side
// assumes a 40 MHz system clock; lock time shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   localparam int LOCK_CYCLES = 20;
   localparam int REF_HALF_NS = 175;
   logic i_clk_sys, i_rst_n, ref_clk, ref_run, i_band_select, i_enable, i_supply_ok, lre;
   logic [4:0] i_ratio_select;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d;
   logic i_wr, i_rd, mp, mn, moe, lp, ln, loe, lock, o_irq;
   int n_fail, n_checks, shift_cnt, n, n_lref;
   logic [4:0] c;

   pcm_top #(.LOCK_CYCLES(LOCK_CYCLES)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_ref_clk_in(ref_clk), .i_ratio_select(i_ratio_select), .i_band_select(i_band_select),
      .i_enable(i_enable), .i_supply_ok(i_supply_ok), .i_link_ref_out_enable(lre),
      .o_mult_clk_out_p(mp), .o_mult_clk_out_n(mn), .o_mult_clk_out_oe_n(moe),
      .o_link_ref_clk_out_p(lp), .o_link_ref_clk_out_n(ln), .o_link_ref_clk_out_oe_n(loe),
      .o_lock_valid_out(lock), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
   pcm_ser #(.HALF_NS(REF_HALF_NS)) u_ser (.i_clk_sys(i_clk_sys), .i_run(ref_run),
      .i_lock_valid_in(lock),
      .i_mult_clk(mp), .i_mult_oe_n(moe), .o_ref_clk(ref_clk), .o_shift_cnt(shift_cnt));

   always #12.5 i_clk_sys = ~i_clk_sys;
   // link reference rises, for the rate check in meas
   always @(posedge lp) n_lref++;

   // ------------------------------------------------------------
   // bench functions and bus tasks
   // ------------------------------------------------------------
   function automatic logic [5:0] exp_ratio(input logic [4:0] k);
      if (k == 5'h00) return 6'h04;
      if (k == 5'h02) return 6'h06;
      if (k inside {[5'h04:5'h06], [5'h08:5'h10]}) return 6'(k) + 6'h04;
      if (k inside {[5'h11:5'h1a]}) return 6'(k - 5'h10) * 6'h02 + 6'h14;
      return 6'h00;
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic pins(input logic [4:0] k, input logic en, input logic sup, input logic le);
      @(posedge i_clk_sys);
      i_ratio_select <= k;
      i_enable <= en;
      i_supply_ok <= sup;
      lre <= le;
   endtask
   // bounded wait for lock; n is the edge count it took
   // at least eight edges, so a pin change just made has dropped lock first
   task automatic wait_lock();
      n = 0;
      while ((lock !== 1'b1 || n < 8) && n < 2000) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      `CHK("lock_wait", 1'b1, lock)
   endtask
   // mult clock rises over ten reference periods, two edges of slack each side
   task automatic meas(input int r);
      int c0, l0;
      @(posedge ref_clk);
      c0 = shift_cnt;
      l0 = n_lref;
      repeat (10) @(posedge ref_clk);
      `CHK("mult_edges", 1'b1, (shift_cnt - c0 >= 10*r - 2 && shift_cnt - c0 <= 10*r + 2))
      `CHK("link_edges", 1'b1, (n_lref - l0 >= 9 && n_lref - l0 <= 11))
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      {i_clk_sys, i_rst_n, i_band_select, i_enable, i_supply_ok, lre, i_wr, i_rd} = '0;
      {i_ratio_select, i_addr, i_wdata} = '0;
      ref_run = 1'b1;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(2950));
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      cyc(1);
      `CHK("reset_oe", 2'b11, {moe, loe})
      `CHK("reset_lock", 1'b0, lock)
      rd(pcm_pkg::ADDR_INT_MASK, d);
      `CHK("mask_rst", 32'h0, d)
      // first lock: timing, driven outputs, ratio 4 and 6 edge counts
      pins(5'h00, 1'b1, 1'b1, 1'b1);
      wait_lock();
      `CHK("lock_time", 1'b1, (n >= LOCK_CYCLES && n <= LOCK_CYCLES + 24))
      `CHK("run_oe", 2'b00, {moe, loe})
      rd(pcm_pkg::ADDR_PERIOD, d);
      `CHK("period", 32'(2 * REF_HALF_NS / 25), d)
      meas(4);
      `CHK("pairs", 2'b11, {mp ^ mn, lp ^ ln})
      pins(5'h02, 1'b1, 1'b1, 1'b1);
      wait_lock();
      meas(6);
      // code change event: unmasked, raises irq, cleared by writing one
      wr(pcm_pkg::ADDR_INT_STAT, 32'hf);
      wr(pcm_pkg::ADDR_INT_MASK, 32'h8);
      pins(5'h04, 1'b1, 1'b1, 1'b1);
      cyc(8);
      `CHK("irq_set", 1'b1, o_irq)
      wr(pcm_pkg::ADDR_INT_STAT, 32'h8);
      cyc(2);
      `CHK("irq_clr", 1'b0, o_irq)
      wr(pcm_pkg::ADDR_INT_MASK, 32'h0);
      // every code: ratio, reserved flag, lock dropped on change
      for (int k = 0; k < 32; k++) begin
         c = 5'(k);
         pins(c, 1'b1, 1'b1, 1'b1);
         cyc(8);
         rd(pcm_pkg::ADDR_STATUS, d);
         `CHK("ratio", exp_ratio(c), d[21:16])
         `CHK("reserved", exp_ratio(c) == 6'h00, d[6])
         `CHK("code_lock", 1'b0, d[0])
      end
      // random codes, band and link enable; lock only on legal codes
      repeat (20) begin
         c = 5'($urandom_range(31));
         pins(c, 1'b1, 1'b1, 1'($urandom));
         i_band_select <= 1'($urandom);
         cyc(55);
         `CHK("rand_lock", exp_ratio(c) != 6'h00, lock)
         `CHK("rand_link", !lre, loe)
         rd(pcm_pkg::ADDR_STATUS, d);
         `CHK("band", i_band_select, d[2])
      end
      // supply low, enable low, link enable low
      pins(5'h00, 1'b1, 1'b0, 1'b1);
      cyc(8);
      `CHK("supply_off", 3'b110, {moe, loe, lock})
      pins(5'h00, 1'b0, 1'b1, 1'b1);
      cyc(8);
      `CHK("en_off", 3'b110, {moe, loe, lock})
      pins(5'h00, 1'b1, 1'b1, 1'b0);
      cyc(8);
      `CHK("link_off", 2'b01, {moe, loe})
      // relock command and reference loss both drop lock
      wait_lock();
      wr(pcm_pkg::ADDR_CTRL, 32'h1);
      cyc(2);
      `CHK("relock", 1'b0, lock)
      wait_lock();
      // start from clean status so only the loss event can show
      wr(pcm_pkg::ADDR_INT_STAT, 32'hf);
      ref_run = 1'b0;
      cyc(30);
      `CHK("ref_loss", 1'b0, lock)
      rd(pcm_pkg::ADDR_INT_STAT, d);
      `CHK("lost_evt", 32'h2, d)
      ref_run = 1'b1;
      // unmapped place reads zero; read data stands one cycle
      wr(8'h40, 32'hffffffff);
      rd(8'h40, d);
      `CHK("unmapped", 32'h0, d)
      rd(pcm_pkg::ADDR_CTRL, d);
      `CHK("ctrl_rd", 32'h0, d)
      cyc(1);
      `CHK("rdata_idle", 32'h0, o_rdata)
      end_sim();
   end

   // watchdog: the run needs about 2000 cycles
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      n_fail++;
      end_sim();
   end
endmodule // tb_top

bind pcm_top pcm_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.i_clk_sys(i_clk_sys),
   .i_rst_n(i_rst_n), .i_ratio_select(i_ratio_select), .i_enable(i_enable),
   .i_supply_ok(i_supply_ok), .i_link_ref_out_enable(i_link_ref_out_enable),
   .o_mult_clk_out_p(o_mult_clk_out_p), .o_mult_clk_out_n(o_mult_clk_out_n),
   .o_mult_clk_out_oe_n(o_mult_clk_out_oe_n),
   .o_link_ref_clk_out_oe_n(o_link_ref_clk_out_oe_n), .o_lock_valid_out(o_lock_valid_out));
`default_nettype wire
